// ==== verilog/pfd_defines.svh ====
`ifndef PFD_DEFINES_SVH
`define PFD_DEFINES_SVH

// ----------------------------------------------------------------
// Bus commands and byte enables (byte enables are active low)
// ----------------------------------------------------------------
`define PFD_CMD_MEMRD   4'h6
`define PFD_CMD_MEMWR   4'h7
`define PFD_BE_ALL      4'h0
`define PFD_BE_TOPBYTE  4'h7
`define PFD_BE_TOPHALF  4'h3

// ----------------------------------------------------------------
// Descriptor offsets and software structure styles
// ----------------------------------------------------------------
`define PFD_OFS_00      8'h00
`define PFD_OFS_04      8'h04
`define PFD_OFS_08      8'h08
`define PFD_STYLE_16    8'h00
`define PFD_STYLE_BURST 8'h03

// ----------------------------------------------------------------
// Address step and reset values
// ----------------------------------------------------------------
`define PFD_DW_STEP     32'h0000_0004
`define PFD_RST_WORD    32'h0000_0000
`define PFD_RST_BE      4'hF
`define PFD_RST_STYLE   8'h00

`endif

// ==== verilog/pfd_pkg.sv ====
// ----------------------------------------------------------------
// Shared types of the bus-master DMA sequencer
// ----------------------------------------------------------------
package pfd_pkg;
	// Bus master sequencer states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_REQ,
		ST_ADDR,
		ST_WAIT,
		ST_DATA,
		ST_TURN
	} pfd_state_e;
endpackage : pfd_pkg

// ==== verilog/pfd_rst_sync.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Reset release synchroniser
// ----------------------------------------------------------------
module pfd_rst_sync (
	input  wire logic clk_sys, // System clock
	input  wire logic nrst,    // Asynchronous reset, active low
	output logic      rstN     // Synchronised reset, active low
);
	logic stage1Ff; // First stage, read only by the second
	logic stage2Ff; // Second stage

	// Assert at once, release two edges later to avoid metastable release
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			stage1Ff <= 1'b0;
			stage2Ff <= 1'b0;
		end else begin
			stage1Ff <= 1'b1;
			stage2Ff <= stage1Ff;
		end
	end

	assign rstN = stage2Ff;
endmodule : pfd_rst_sync

// ==== verilog/pfd_two_buf.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Two-entry buffer with valid and ready on both sides
// ----------------------------------------------------------------
module pfd_two_buf #(
	parameter int W = 32 // Word width
) (
	input  wire logic         clk_sys,  // System clock
	input  wire logic         rstN,     // Synchronous-release reset, active low
	input  wire logic         inValid,  // Word offered
	output logic              inReady,  // Room for a word
	input  wire logic [W-1:0] inData,   // Word in
	output logic              outValid, // Word available
	input  wire logic         outReady, // Receiver takes the word
	output logic      [W-1:0] outData   // Oldest word
);
	logic [W-1:0] memFf [2]; // Storage entries
	logic         wrPtrFf;   // Next entry to fill
	logic         rdPtrFf;   // Oldest entry
	logic [1:0]   cntFf;     // Words held

	wire doPush = inValid && inReady;   // Accepted write
	wire doPop  = outValid && outReady; // Accepted read

	assign inReady  = (cntFf != 2'h2);
	assign outValid = (cntFf != 2'h0);
	assign outData  = memFf[rdPtrFf];

	// Pointers and count; a push and a pop together keep the count
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			wrPtrFf <= 1'b0;
			rdPtrFf <= 1'b0;
			cntFf   <= 2'h0;
		end else begin
			if (doPush) wrPtrFf <= ~wrPtrFf;
			if (doPop) rdPtrFf <= ~rdPtrFf;
			cntFf <= cntFf + {1'b0, doPush} - {1'b0, doPop};
		end
	end

	// Storage needs no reset; it is only read while counted valid
	always_ff @(posedge clk_sys) begin
		if (doPush) memFf[wrPtrFf] <= inData;
	end
endmodule : pfd_two_buf

// ==== verilog/pfd_dma_master.sv ====
`timescale 1ns/1ps
`include "pfd_defines.svh"
// Function
// - 16-bit: 04h word, idle, top byte 00h
// - Style 2: 08h doubleword, idle, upper half 04h
// - Style 3: 00h then 04h, burst if enabled
// - FIFO moves only between memory and FIFOs
// - Several transfers per mastership before release
// - One direction per mastership period
// - FIFO addresses contiguous and ascending
// - Non-burst supported; burst optional on PCI
// - FIFO transfers always non-burst, even with burst enabled
// - Address then data phase with byte enables
// - FRAME dropped after every FIFO address phase
// - Reads stop at transmit high watermark
// - Writes stop at receive low watermark
// - Late arriving doubleword joins the period
// - Latency timer ignored for non-burst FIFO
// - Descriptor writes get one IRDY wait state
// - Chain intermediate update is single transfer
module pfd_dma_master
	import pfd_pkg::*;
#(
	parameter int LW = 8 // FIFO level width
) (
	input  wire logic          clk_sys,      // System clock, 25 MHz
	input  wire logic          nrst,         // Asynchronous reset, active low
	input  wire logic [7:0]    software_structure_style,      // software_structure_style setting
	input  wire logic          burstWriteEn, // burst_write_enable setting
	input  wire logic          descStart,    // Descriptor update request pulse
	input  wire logic          descSingle,   // Intermediate chain buffer update
	input  wire logic [31:0]   descBase,     // Descriptor base address
	input  wire logic [31:0]   descWordOne,  // descriptor_word_one image
	input  wire logic [31:0]   descWordTwo,  // descriptor_word_two image
	input  wire logic          fifoStart,    // FIFO transfer request pulse
	input  wire logic          fifoWrite,    // 1: receive FIFO to memory
	input  wire logic [31:0]   fifoAddr,     // First FIFO transfer address
	input  wire logic [LW-1:0] txLevel,      // Transmit FIFO fill level
	input  wire logic [LW-1:0] txHighWm,     // Transmit high watermark
	input  wire logic [LW-1:0] rxLevel,      // Receive FIFO fill level
	input  wire logic [LW-1:0] rxLowWm,      // Receive low watermark
	input  wire logic [31:0]   rxData,       // Receive FIFO head word
	input  wire logic          rxValid,      // Receive head word valid
	output logic               rxReady,      // Receive head word taken
	output logic [31:0]        txData,       // Word for transmit FIFO
	output logic               txValid,      // Transmit word valid
	input  wire logic          txReady,      // Transmit FIFO accepts
	output logic               busy,         // Sequencer active
	output logic               xferDone,     // Period finished pulse
	output logic               reqNOut,      // Bus request, active low
	input  wire logic          gntNIn,       // Bus grant, active low
	output logic [31:0]        adOut,        // Address/data out
	output logic               adOe,         // Address/data drive enable
	input  wire logic [31:0]   adIn,         // Address/data in
	output logic [3:0]         cbeNOut,      // Command/byte enables out
	output logic               cbeOe,        // Command/byte drive enable
	output logic               frameNOut,    // FRAME out, active low
	output logic               frameOe,      // FRAME drive enable
	output logic               irdyNOut,     // IRDY out, active low
	output logic               irdyOe,       // IRDY drive enable
	input  wire logic          trdyNIn       // TRDY in, active low
);
	// ----------------------------------------------------------------
	// Helper functions for descriptor layout
	// ----------------------------------------------------------------

	// Offset of a descriptor write for a style and transfer number
	function automatic logic [7:0] descOffset(input logic [7:0] sty,
		input logic ph);
		if (sty == `PFD_STYLE_16) begin
			descOffset = ph ? `PFD_OFS_00 : `PFD_OFS_04;
		end else if (sty == `PFD_STYLE_BURST) begin
			descOffset = ph ? `PFD_OFS_04 : `PFD_OFS_00;
		end else begin
			descOffset = ph ? `PFD_OFS_04 : `PFD_OFS_08;
		end
	endfunction : descOffset

	// Data word of a descriptor write
	function automatic logic [31:0] descData(input logic [7:0] sty,
		input logic ph, input logic [31:0] w1, input logic [31:0] w2);
		if (sty == `PFD_STYLE_16) begin
			descData = ph ? {w1[31:24], 24'h00_0000} : {w2[15:0], w1[15:0]};
		end else begin
			descData = ph ? {w1[31:16], 16'h0000} : w2;
		end
	endfunction : descData

	// Byte enables of a descriptor write, active low
	function automatic logic [3:0] descBe(input logic [7:0] sty,
		input logic ph);
		if (!ph) begin
			descBe = `PFD_BE_ALL;
		end else if (sty == `PFD_STYLE_16) begin
			descBe = `PFD_BE_TOPBYTE;
		end else begin
			descBe = `PFD_BE_TOPHALF;
		end
	endfunction : descBe

	// ----------------------------------------------------------------
	// State and storage
	// ----------------------------------------------------------------
	logic        rstN;          // Released reset copy
	pfd_state_e  stFf;          // Sequencer state
	pfd_state_e  nxt_st;        // Next state
	logic        isFifoFf;      // Current period is a FIFO transfer
	logic        dirFf;         // 1: memory write
	logic        phaseFf;       // Descriptor transfer number
	logic        burstFf;       // Descriptor pair as one burst
	logic [7:0]  styleFf;       // Captured structure style
	logic [31:0] baseFf;        // Descriptor base
	logic [31:0] w1Ff;          // Word one image
	logic [31:0] w2Ff;          // Word two image
	logic [31:0] fAddrFf;       // Current FIFO address
	logic [31:0] adFf;          // Address/data pin register
	logic [3:0]  cbeFf;         // Command/byte enable pin register
	logic        doneFf;        // Done pulse register
	logic        nxt_isFifo;    // Next FIFO flag
	logic        nxt_dir;       // Next direction
	logic        nxt_phase;     // Next transfer number
	logic        nxt_burst;     // Next burst flag
	logic [7:0]  nxt_style;     // Next style
	logic [31:0] nxt_base;      // Next base
	logic [31:0] nxt_w1;        // Next word one
	logic [31:0] nxt_w2;        // Next word two
	logic [31:0] nxt_fAddr;     // Next FIFO address
	logic [31:0] nxt_ad;        // Next pin word
	logic [3:0]  nxt_cbe;       // Next command/byte enables
	logic        nxt_done;      // Next done pulse
	logic        bufInReady;    // Buffer has room

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	wire stIdle = (stFf == ST_IDLE); // Idle
	wire stReq  = (stFf == ST_REQ);  // Requesting
	wire stAddr = (stFf == ST_ADDR); // Address phase
	wire stWait = (stFf == ST_WAIT); // Descriptor wait state
	wire stData = (stFf == ST_DATA); // Data phase
	wire stTurn = (stFf == ST_TURN); // Idle cycle after a transaction
	wire hasGnt = !gntNIn;           // Grant held
	wire lastPh = phaseFf;           // Second descriptor transfer

	// Watermark checks are re-evaluated live, so a late word extends
	// the period without extra logic
	wire fifoRdMore = !dirFf && (txLevel < txHighWm);
	wire fifoWrMore = dirFf && (rxLevel > rxLowWm) && rxValid;
	wire fifoMore   = fifoRdMore || fifoWrMore;
	// Reads only start with buffer room, so a stalled receiver
	// holds the next address phase back instead of losing data
	wire fifoReady  = dirFf || bufInReady;
	wire fifoEnd    = isFifoFf && !fifoMore;
	wire dataOk     = stData && !trdyNIn;  // Data phase completes
	wire [3:0] fifoCmd = dirFf ? `PFD_CMD_MEMWR : `PFD_CMD_MEMRD; // Full command nibble

	// Descriptor pin words for both transfers
	wire [31:0] descAddrNow = baseFf + {24'h00_0000, descOffset(styleFf, phaseFf)};
	wire [31:0] descAddrTwo = baseFf + {24'h00_0000, descOffset(styleFf, 1'b1)};
	wire [31:0] descDataNow = descData(styleFf, phaseFf, w1Ff, w2Ff);
	wire [31:0] descDataTwo = descData(styleFf, 1'b1, w1Ff, w2Ff);
	wire [31:0] fAddrNext   = fAddrFf + `PFD_DW_STEP;
	wire        startBurst  = (software_structure_style == `PFD_STYLE_BURST) && burstWriteEn
		&& !descSingle;

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------

	// Next-state logic; the latency timer has no input here, so the
	// period only ends by watermark; a lost grant only waits in ST_REQ
	always_comb begin
		nxt_st     = stFf;
		nxt_isFifo = isFifoFf;
		nxt_dir    = dirFf;
		nxt_phase  = phaseFf;
		nxt_burst  = burstFf;
		nxt_style  = styleFf;
		nxt_base   = baseFf;
		nxt_w1     = w1Ff;
		nxt_w2     = w2Ff;
		nxt_fAddr  = fAddrFf;
		nxt_ad     = adFf;
		nxt_cbe    = cbeFf;
		nxt_done   = 1'b0;
		case (stFf)
			ST_IDLE: begin
				// Descriptor work wins when both arrive together
				if (descStart) begin
					nxt_st     = ST_REQ;
					nxt_isFifo = 1'b0;
					nxt_dir    = 1'b1;
					nxt_phase  = descSingle;
					nxt_burst  = startBurst;
					nxt_style  = software_structure_style;
					nxt_base   = descBase;
					nxt_w1     = descWordOne;
					nxt_w2     = descWordTwo;
				end else if (fifoStart) begin
					nxt_st     = ST_REQ;
					nxt_isFifo = 1'b1;
					nxt_burst  = 1'b0; // A past descriptor burst must not leak
					nxt_dir    = fifoWrite;
					nxt_fAddr  = fifoAddr;
				end
			end
			ST_REQ: begin
				if (fifoEnd) begin
					nxt_st   = ST_IDLE;
					nxt_done = 1'b1;
				end else if (hasGnt && (!isFifoFf || fifoReady)) begin
					nxt_st  = ST_ADDR;
					nxt_ad  = isFifoFf ? fAddrFf : descAddrNow;
					nxt_cbe = isFifoFf ? fifoCmd : `PFD_CMD_MEMWR;
				end
			end
			ST_ADDR: begin
				// Data word and byte enables follow the address
				nxt_ad  = isFifoFf ? rxData : descDataNow;
				nxt_cbe = isFifoFf ? `PFD_BE_ALL : descBe(styleFf, phaseFf);
				nxt_st  = isFifoFf ? ST_DATA : ST_WAIT;
			end
			ST_WAIT: begin
				nxt_st = ST_DATA;
			end
			ST_DATA: begin
				// No master abort timeout: a silent target hangs here
				if (!trdyNIn) begin
					if (burstFf && !lastPh) begin
						nxt_st    = ST_WAIT;
						nxt_phase = 1'b1;
						nxt_ad    = descDataTwo;
						nxt_cbe   = descBe(styleFf, 1'b1);
					end else begin
						nxt_st = ST_TURN;
					end
				end
			end
			ST_TURN: begin
				if (!isFifoFf) begin
					if (lastPh) begin
						nxt_st   = ST_IDLE;
						nxt_done = 1'b1;
					end else begin
						nxt_phase = 1'b1;
						nxt_st    = hasGnt ? ST_ADDR : ST_REQ;
						nxt_ad    = descAddrTwo;
						nxt_cbe   = `PFD_CMD_MEMWR;
					end
				end else begin
					nxt_fAddr = fAddrNext;
					if (!fifoMore) begin
						nxt_st   = ST_IDLE;
						nxt_done = 1'b1;
					end else if (hasGnt && fifoReady) begin
						nxt_st  = ST_ADDR;
						nxt_ad  = fAddrNext;
						nxt_cbe = fifoCmd;
					end else begin
						nxt_st = ST_REQ;
					end
				end
			end
			default: begin
				nxt_st = ST_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			stFf   <= ST_IDLE;
			doneFf <= 1'b0;
		end else begin
			stFf   <= nxt_st;
			doneFf <= nxt_done;
		end
	end

	// Transfer context
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			isFifoFf <= 1'b0;
			dirFf    <= 1'b0;
			phaseFf  <= 1'b0;
			burstFf  <= 1'b0;
			styleFf  <= `PFD_RST_STYLE;
		end else begin
			isFifoFf <= nxt_isFifo;
			dirFf    <= nxt_dir;
			phaseFf  <= nxt_phase;
			burstFf  <= nxt_burst;
			styleFf  <= nxt_style;
		end
	end

	// Words and pin registers
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			baseFf  <= `PFD_RST_WORD;
			w1Ff    <= `PFD_RST_WORD;
			w2Ff    <= `PFD_RST_WORD;
			fAddrFf <= `PFD_RST_WORD;
			adFf    <= `PFD_RST_WORD;
			cbeFf   <= `PFD_RST_BE;
		end else begin
			baseFf  <= nxt_base;
			w1Ff    <= nxt_w1;
			w2Ff    <= nxt_w2;
			fAddrFf <= nxt_fAddr;
			adFf    <= nxt_ad;
			cbeFf   <= nxt_cbe;
		end
	end

	// ----------------------------------------------------------------
	// Pins and user side
	// ----------------------------------------------------------------
	// Request drops in the cycle the ending condition is seen
	assign reqNOut   = stIdle || (stReq && fifoEnd)
		|| (stTurn && (isFifoFf ? !fifoMore : lastPh));
	assign frameOe   = stAddr || stWait || stData || stTurn;
	// FRAME stays low across a wait so it only rises with IRDY low
	assign frameNOut = !(stAddr || stWait
		|| (stData && !isFifoFf && burstFf && !lastPh));
	assign irdyOe    = stWait || stData || stTurn;
	assign irdyNOut  = !stData;
	assign adOe      = stAddr || ((stWait || stData) && dirFf);
	assign adOut     = adFf;
	assign cbeOe     = stAddr || stWait || stData;
	assign cbeNOut   = cbeFf;
	assign rxReady   = dataOk && isFifoFf && dirFf;
	assign busy      = !stIdle;
	assign xferDone  = doneFf;

	// Read words buffered toward the transmit FIFO
	pfd_two_buf #(
		.W(32)
	) uRdBuf (
		.clk_sys  (clk_sys),
		.rstN     (rstN),
		.inValid  (dataOk && isFifoFf && !dirFf),
		.inReady  (bufInReady),
		.inData   (adIn),
		.outValid (txValid),
		.outReady (txReady),
		.outData  (txData)
	);

	// Reset release
	pfd_rst_sync uRst (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.rstN    (rstN)
	);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cbDef @(posedge clk_sys); endclocking
	default disable iff (!rstN);

	logic [31:0] prevAddrFf; // Last address phase word
	logic        seenAddrFf; // A FIFO address phase already in period
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			prevAddrFf <= `PFD_RST_WORD;
			seenAddrFf <= 1'b0;
		end else begin
			if (stAddr) prevAddrFf <= adFf;
			seenAddrFf <= stIdle ? 1'b0 : (seenAddrFf || (stAddr && isFifoFf));
		end
	end

	sequence s_waitThenData;
		stWait && irdyOe && irdyNOut ##1 stData && !irdyNOut;
	endsequence

	property p_style16First;
		stAddr && !isFifoFf && styleFf == `PFD_STYLE_16 && !phaseFf
			|-> adFf[7:0] == `PFD_OFS_04;
	endproperty
	a_style16First: assert property (p_style16First) else $error("16-bit first offset");

	property p_style16Second;
		stTurn && !isFifoFf && styleFf == `PFD_STYLE_16 && !phaseFf && hasGnt
			|=> stAddr && adFf[7:0] == `PFD_OFS_00 ##2 cbeNOut == `PFD_BE_TOPBYTE;
	endproperty
	a_style16Second: assert property (p_style16Second) else $error("16-bit second write");

	property p_style2First;
		stAddr && !isFifoFf && styleFf != `PFD_STYLE_16
			&& styleFf != `PFD_STYLE_BURST && !phaseFf |-> adFf[7:0] == `PFD_OFS_08;
	endproperty
	a_style2First: assert property (p_style2First) else $error("style 2 first offset");

	property p_style3Burst;
		dataOk && burstFf && !phaseFf |=> s_waitThenData and !frameNOut;
	endproperty
	a_style3Burst: assert property (p_style3Burst) else $error("style 3 burst broken");

	property p_descWait;
		stAddr && !isFifoFf |=> s_waitThenData;
	endproperty
	a_descWait: assert property (p_descWait) else $error("missing wait state");

	property p_fifoFrame;
		stData && isFifoFf |-> frameNOut && frameOe && !irdyNOut;
	endproperty
	a_fifoFrame: assert property (p_fifoFrame) else $error("FRAME held in FIFO data");

	property p_ascend;
		stAddr && isFifoFf && seenAddrFf |-> adFf == prevAddrFf + `PFD_DW_STEP;
	endproperty
	a_ascend: assert property (p_ascend) else $error("FIFO address not ascending");

	property p_oneDir;
		!reqNOut && !$past(reqNOut) |-> $stable(dirFf) && $stable(isFifoFf);
	endproperty
	a_oneDir: assert property (p_oneDir) else $error("direction changed in period");

	property p_grant;
		stAddr |-> $past(hasGnt);
	endproperty
	a_grant: assert property (p_grant) else $error("address phase without grant");

	property p_txStop;
		stTurn && isFifoFf && !dirFf && txLevel >= txHighWm
			|-> !reqNOut == 1'b0 ##1 stIdle && xferDone;
	endproperty
	a_txStop: assert property (p_txStop) else $error("read past high watermark");

	property p_rxStop;
		stTurn && isFifoFf && dirFf && rxLevel <= rxLowWm
			|-> reqNOut ##1 stIdle && xferDone;
	endproperty
	a_rxStop: assert property (p_rxStop) else $error("write past low watermark");
endmodule : pfd_dma_master

// ==== dv/pfd_target_model.sv ====
`timescale 1ns/1ps
`include "pfd_defines.svh"
// ------------------------------------
// Bus target: host bridge plus memory
// ------------------------------------
module pfd_target_model (
	input  wire logic        clk_sys,   // System clock
	input  wire logic [1:0]  lag,       // Wait states before TRDY
	input  wire logic        reqNOut,   // Request from master
	output logic             gntNIn,    // Grant to master
	input  wire logic        frameNOut, // FRAME level
	input  wire logic        frameOe,   // FRAME enable
	input  wire logic        irdyNOut,  // IRDY level
	input  wire logic        irdyOe,    // IRDY enable
	input  wire logic [31:0] adOut,     // Master address/data
	input  wire logic [3:0]  cbeNOut,   // Master command
	output logic             trdyNIn,   // TRDY to master
	output logic [31:0]      adIn       // Read data
);
	logic [31:0] addr;   // Latched read address
	logic [1:0]  cnt;    // Waits spent so far
	logic        irdyOn; // Master ready
	assign irdyOn  = irdyOe && !irdyNOut;
	assign trdyNIn = !(irdyOn && cnt >= lag);
	// The lines carry read data whenever TRDY is low, and inverted adOut junk otherwise
	assign adIn = trdyNIn ? ~adOut : addr ^ 32'h5A5A_0000;
	initial gntNIn = 1'b1;
	// Grant follows request by one cycle, so a start needs it first
	always @(posedge clk_sys) begin
		gntNIn <= reqNOut;
		cnt <= (irdyOn && trdyNIn) ? cnt + 2'h1 : 2'h0;
		if (frameOe && !frameNOut && cbeNOut == `PFD_CMD_MEMRD) begin
			addr <= adOut;
		end
	end
endmodule : pfd_target_model

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
`include "pfd_defines.svh"
`define CHK(n, e, g) begin \
	cmp_count++; \
	if ((g) !== (e)) begin \
		fails++; \
		$display("unexpected %s exp %h got %h", n, e, g); \
	end \
end
module tb_top;
	typedef struct packed {
		logic [7:0] st; logic bw; logic sg; logic [1:0] na; logic [1:0] nd;
		logic [7:0] a0; logic [31:0] d0; logic [3:0] b0;
		logic [7:0] a1; logic [31:0] d1; logic [3:0] b1;
	} pfd_row_s;
	localparam logic [31:0] BASE = 32'h0000_1000;
	localparam logic [31:0] W1   = 32'hC3D2_B1A0;
	localparam logic [31:0] W2   = 32'h8765_4321;
	localparam logic [31:0] DA   = {W2[15:0], W1[15:0]};
	localparam logic [31:0] DB   = {W1[31:24], 24'h0};
	localparam logic [31:0] DH   = {W1[31:16], 16'h0};
	// Style, burst, single, address and data phases, then each transfer
	localparam pfd_row_s ROWS [7] = '{
		'{8'h00, 1'h0, 1'h0, 2'h2, 2'h2, 8'h04, DA, 4'h0, 8'h00, DB, 4'h7},
		'{8'h02, 1'h0, 1'h0, 2'h2, 2'h2, 8'h08, W2, 4'h0, 8'h04, DH, 4'h3},
		'{8'h02, 1'h1, 1'h0, 2'h2, 2'h2, 8'h08, W2, 4'h0, 8'h04, DH, 4'h3},
		'{8'h03, 1'h0, 1'h0, 2'h2, 2'h2, 8'h00, W2, 4'h0, 8'h04, DH, 4'h3},
		'{8'h02, 1'h0, 1'h1, 2'h1, 2'h1, 8'h04, DH, 4'h3, 8'h04, DH, 4'h3},
		'{8'h00, 1'h0, 1'h1, 2'h1, 2'h1, 8'h00, DB, 4'h7, 8'h00, DB, 4'h7},
		'{8'h03, 1'h1, 1'h0, 2'h1, 2'h2, 8'h00, W2, 4'h0, 8'h04, DH, 4'h3}};
	logic        clk_sys, nrst, burstWriteEn, descStart, descSingle, fifoStart, fifoWrite;
	logic        rxValid, txReady, bump, rxReady, txValid, busy, xferDone, reqNOut;
	logic        gntNIn, adOe, cbeOe, frameNOut, frameOe, irdyNOut, irdyOe, trdyNIn, fl, rq;
	logic [1:0]  lag;
	logic [7:0]  software_structure_style, txLevel, txHighWm, rxLevel, rxLowWm;
	logic [31:0] fifoAddr, rxData, txData, adOut, adIn, cur;
	logic [3:0]  cbeNOut;
	int          fails, cmp_count, nA, nW, nR;
	logic [31:0] qa[$], qd[$], pops[$];
	logic [3:0]  qb[$], qc[$];
	pfd_dma_master uut (.clk_sys, .nrst, .software_structure_style, .burstWriteEn, .descStart, .descSingle,
		.descBase(BASE), .descWordOne(W1), .descWordTwo(W2), .fifoStart, .fifoWrite,
		.fifoAddr, .txLevel, .txHighWm, .rxLevel, .rxLowWm, .rxData, .rxValid, .rxReady,
		.txData, .txValid, .txReady, .busy, .xferDone, .reqNOut, .gntNIn, .adOut, .adOe,
		.adIn, .cbeNOut, .cbeOe, .frameNOut, .frameOe, .irdyNOut, .irdyOe, .trdyNIn);
	pfd_target_model tgt (.clk_sys, .lag, .reqNOut, .gntNIn, .frameNOut, .frameOe,
		.irdyNOut, .irdyOe, .adOut, .cbeNOut, .trdyNIn, .adIn);
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	// ----------------------------------------
	// Bus monitor and FIFO-side responders
	// ----------------------------------------
	always @(posedge clk_sys) begin
		fl <= frameOe && !frameNOut;
		rq <= reqNOut;
		if (reqNOut && !rq) nR++;
		// Wait cycle: FRAME held past the address phase with IRDY high
		if (fl && frameOe && !frameNOut && irdyOe && irdyNOut) nW++;
		if (frameOe && !frameNOut && !fl) begin
			nA++;
			qc.push_back(cbeNOut);
			cur = adOut;
			`CHK("grant at address", 1'b0, gntNIn)
			`CHK("address phase drive", 2'h3, {adOe, cbeOe})
		end
		if (irdyOe && !irdyNOut && !trdyNIn) begin
			qa.push_back(cur);
			qd.push_back(adOe ? adOut : adIn);
			qb.push_back(cbeNOut);
			cur = cur + 32'h4;
		end
		if (txValid && txReady) begin
			txLevel <= txLevel + 8'h1;
			pops.push_back(txData);
		end
		// A held level models a doubleword arriving mid-period
		if (rxReady) begin
			rxData <= rxData + 32'h1;
			rxLevel <= bump ? rxLevel : rxLevel - 8'h1;
			bump <= 1'b0;
		end
	end
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : wrap_up
	// One start pulse, then a bounded wait for the done pulse
	task automatic go(input logic fifo);
		qa.delete(); qd.delete(); qb.delete(); qc.delete(); pops.delete();
		nA = 0;
		nW = 0;
		nR = 0;
		if (fifo) fifoStart <= 1'b1;
		else descStart <= 1'b1;
		@(posedge clk_sys);
		fifoStart <= 1'b0;
		descStart <= 1'b0;
		for (int k = 0; k < 3000; k++) begin
			@(posedge clk_sys);
			if (xferDone === 1'b1) return;
		end
		fails++;
		wrap_up();
	endtask : go
	task automatic fifo_chk(input logic [3:0] cmd, input logic [31:0] a);
		`CHK("releases", 1, nR)
		`CHK("fifo waits", 0, nW)
		`CHK("one data per address", qa.size(), nA)
		for (int i = 0; i < qa.size(); i++) begin
			`CHK("fifo cmd", cmd, qc[i])
			`CHK("fifo addr", a + 32'(4 * i), qa[i])
			`CHK("fifo be", 4'h0, qb[i])
		end
	endtask : fifo_chk
	initial begin
		{nrst, burstWriteEn, descStart, descSingle, fifoStart, fifoWrite, bump} = '0;
		{software_structure_style, txLevel, txHighWm, rxLevel, rxLowWm, lag, fifoAddr, rxData} = '0;
		rxValid = 1'b1;
		txReady = 1'b1;
		repeat (4) @(posedge clk_sys);
		nrst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		`CHK("reset request", 1'b1, reqNOut)
		`CHK("reset busy", 1'b0, busy)
		for (int r = 0; r < 7; r++) begin
			software_structure_style <= ROWS[r].st;
			burstWriteEn <= ROWS[r].bw;
			descSingle <= ROWS[r].sg;
			go(1'b0);
			`CHK("desc addr phases", int'(ROWS[r].na), nA)
			`CHK("desc wait states", int'(ROWS[r].nd), nW)
			`CHK("desc data phases", int'(ROWS[r].nd), qa.size())
			`CHK("desc cmd", `PFD_CMD_MEMWR, qc[0])
			for (int i = 0; i < ROWS[r].nd; i++) begin
				`CHK("desc addr", BASE + {24'h0, i ? ROWS[r].a1 : ROWS[r].a0}, qa[i])
				`CHK("desc data", i ? ROWS[r].d1 : ROWS[r].d0, qd[i])
				`CHK("desc be", i ? ROWS[r].b1 : ROWS[r].b0, qb[i])
			end
		end
		// Memory reads with the transmit side stalled, filling the buffer
		txHighWm <= 8'h03;
		txReady <= 1'b0;
		fifoAddr <= 32'h0000_2000;
		fork
			begin
				repeat (30) @(posedge clk_sys);
				txReady <= 1'b1;
			end
		join_none
		go(1'b1);
		repeat (4) @(posedge clk_sys);
		fifo_chk(`PFD_CMD_MEMRD, 32'h0000_2000);
		`CHK("read count", 1'b1, qa.size() >= 3 && qa.size() <= 5)
		`CHK("popped words", qa.size(), pops.size())
		for (int i = 0; i < pops.size(); i++) begin
			`CHK("tx word", qa[i] ^ 32'h5A5A_0000, pops[i])
		end
		// Watermark already met: no bus cycle at all
		go(1'b1);
		`CHK("refused reads", 0, nA)
		// Memory writes with a slow target and one late doubleword
		rxLevel <= 8'h04;
		rxLowWm <= 8'h01;
		rxData <= 32'hD000_0000;
		fifoWrite <= 1'b1;
		fifoAddr <= 32'h0000_3000;
		lag <= 2'h2;
		bump <= 1'b1;
		go(1'b1);
		fifo_chk(`PFD_CMD_MEMWR, 32'h0000_3000);
		`CHK("write count", 4, qa.size())
		for (int i = 0; i < qd.size(); i++) begin
			`CHK("rx word", 32'hD000_0000 + 32'(i), qd[i])
		end
		// Reset in mid-transfer, then a clean descriptor update
		descStart <= 1'b1;
		repeat (3) @(posedge clk_sys);
		descStart <= 1'b0;
		nrst <= 1'b0;
		@(posedge clk_sys);
		`CHK("mid reset", 7'h4F, {reqNOut, busy, frameOe, cbeNOut})
		nrst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		go(1'b0);
		`CHK("after reset", int'(ROWS[6].na), nA)
		wrap_up();
	end
endmodule : tb_top
